// ### tss_port.sv
/*
  three-line time sync serial port: heartbeat, shift clock and time code.
  assumes drive_mode and time_in come from core logic on clk; the three
  line inputs come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "tss_params.svh"

module tss_port
(
  input wire logic clk,
  input wire logic srst,
  input wire logic drive_mode,
  input wire logic [`TSS_CODE_W-1:0] time_in,
  input wire logic heartbeat_line_i,
  output logic heartbeat_line_o,
  output logic heartbeat_line_oe_n,
  input wire logic time_shift_clock_i,
  output logic time_shift_clock_o,
  output logic time_shift_clock_oe_n,
  input wire logic serial_time_code_i,
  output logic serial_time_code_o,
  output logic serial_time_code_oe_n,
  output logic tx_stamp,
  output logic [`TSS_CODE_W-1:0] rx_time,
  output logic rx_valid,
  output logic rx_hb_mark,
  output logic rx_frame_err
);

  tss_tick_if tick();

  tss_bit_divider u_div
  (
    .clk(clk),
    .srst(srst),
    .tick(tick)
  );

  // ==========================================================
  // direction
  logic mode_r;
  logic oe_n_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      mode_r <= drive_mode;
      oe_n_r <= ~drive_mode;
    end
  end

  assign tick.run = mode_r;
  assign heartbeat_line_oe_n = oe_n_r;
  assign time_shift_clock_oe_n = oe_n_r;
  assign serial_time_code_oe_n = oe_n_r;
  assign time_shift_clock_o = tick.lvl;

  // ==========================================================
  // line synchronisers
  logic hb_s1, hb_s2, sc_s1, sc_s2, sc_s3, cd_s1, cd_s2;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {hb_s1, hb_s2, sc_s1, sc_s2, sc_s3, cd_s1, cd_s2} <= 7'h00;
    end
    else
    begin
      hb_s1 <= heartbeat_line_i;
      hb_s2 <= hb_s1;
      sc_s1 <= time_shift_clock_i;
      sc_s2 <= sc_s1;
      sc_s3 <= sc_s2;
      cd_s1 <= serial_time_code_i;
      cd_s2 <= cd_s1;
    end
  end

  // ==========================================================
  // transmit (driving) side
  logic hb_o_r, hb_o_nxt, code_o_r, code_o_nxt, stamp_r, stamp_nxt;
  logic [`TSS_CODE_W-1:0] tx_sh_r, tx_sh_nxt;

  always_comb
  begin
    hb_o_nxt = hb_o_r;
    code_o_nxt = code_o_r;
    tx_sh_nxt = tx_sh_r;
    stamp_nxt = 1'b0;
    if (!mode_r)
    begin
      hb_o_nxt = 1'b0;
      code_o_nxt = 1'b0;
    end
    else if (tick.rise_pre)
    begin
      if (tick.bit_idx == '0)
      begin
        hb_o_nxt = 1'b1;
        stamp_nxt = 1'b1;
        code_o_nxt = time_in[`TSS_CODE_W-1];
        tx_sh_nxt = {time_in[`TSS_CODE_W-2:0], 1'b0};
      end
      else
      begin
        hb_o_nxt = 1'b0;
        code_o_nxt = tx_sh_r[`TSS_CODE_W-1];
        tx_sh_nxt = {tx_sh_r[`TSS_CODE_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hb_o_r <= 1'b0;
      code_o_r <= 1'b0;
      tx_sh_r <= '0;
      stamp_r <= 1'b0;
    end
    else
    begin
      hb_o_r <= hb_o_nxt;
      code_o_r <= code_o_nxt;
      tx_sh_r <= tx_sh_nxt;
      stamp_r <= stamp_nxt;
    end
  end

  assign heartbeat_line_o = hb_o_r;
  assign serial_time_code_o = code_o_r;
  assign tx_stamp = stamp_r;

  // ==========================================================
  // receive (sampling) side
  tss_pkg::tss_rx_state_t rx_st_r, rx_st_nxt;
  logic [`TSS_CODE_W-1:0] rx_sh_r, rx_sh_nxt, rx_time_r, rx_time_nxt;
  logic [`TSS_CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
  logic hb_prev_r, hb_prev_nxt, valid_r, valid_nxt;
  logic mark_r, mark_nxt, err_r, err_nxt;
  logic sc_fall, hb_start;

  always_comb
  begin
    sc_fall = ~mode_r & tss_pkg::tss_fell(sc_s3, sc_s2);
    hb_start = tss_pkg::tss_rose(hb_prev_r, hb_s2);
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_time_nxt = rx_time_r;
    hb_prev_nxt = hb_prev_r;
    valid_nxt = 1'b0;
    mark_nxt = 1'b0;
    err_nxt = 1'b0;
    if (mode_r)
    begin
      rx_st_nxt = tss_pkg::RX_IDLE;
      hb_prev_nxt = 1'b0;
    end
    else if (sc_fall)
    begin
      hb_prev_nxt = hb_s2;
      rx_sh_nxt = {rx_sh_r[`TSS_CODE_W-2:0], cd_s2};
      rx_cnt_nxt = rx_cnt_r + 1'b1;
      case (rx_st_r)
        tss_pkg::RX_IDLE:
        begin
          if (hb_start)
          begin
            mark_nxt = 1'b1;
            rx_cnt_nxt = '0;
            rx_st_nxt = tss_pkg::RX_SHIFT;
          end
        end
        tss_pkg::RX_SHIFT:
        begin
          if (hb_start)
          begin
            err_nxt = 1'b1;
            mark_nxt = 1'b1;
            rx_cnt_nxt = '0;
          end
          else if (rx_cnt_r == `TSS_CODE_LAST - 6'h01)
          begin
            rx_time_nxt = {rx_sh_r[`TSS_CODE_W-2:0], cd_s2};
            valid_nxt = 1'b1;
            rx_st_nxt = tss_pkg::RX_IDLE;
          end
        end
        default:
        begin
          rx_st_nxt = tss_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_st_r <= tss_pkg::RX_IDLE;
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
      rx_time_r <= '0;
      hb_prev_r <= 1'b0;
      valid_r <= 1'b0;
      mark_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_time_r <= rx_time_nxt;
      hb_prev_r <= hb_prev_nxt;
      valid_r <= valid_nxt;
      mark_r <= mark_nxt;
      err_r <= err_nxt;
    end
  end

  assign rx_time = rx_time_r;
  assign rx_valid = valid_r;
  assign rx_hb_mark = mark_r;
  assign rx_frame_err = err_r;

  // ==========================================================
  // checks
  logic [7:0] chk_falls;

  always_ff @(posedge clk)
  begin
    if (srst || rx_hb_mark)
    begin
      chk_falls <= 8'h00;
    end
    else if (sc_fall)
    begin
      chk_falls <= chk_falls + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_hb_pulse;
    heartbeat_line_o [*8] ##1 !heartbeat_line_o;
  endsequence

  sequence s_drv_switch;
    $changed(drive_mode) ##1 1'b1;
  endsequence

  a_pins_same_dir: assert property (
    heartbeat_line_oe_n == ~mode_r && serial_time_code_oe_n == ~mode_r
    && time_shift_clock_oe_n == ~mode_r)
    else $error("line enables disagree with mode");
  a_dir_follows_mode: assert property (
    s_drv_switch |-> heartbeat_line_oe_n == ~$past(drive_mode))
    else $error("direction did not follow mode");
  a_hb_opens_frame: assert property (
    mode_r && tick.rise_pre && tick.bit_idx == '0
    |=> heartbeat_line_o && tx_stamp)
    else $error("heartbeat missing at frame start");
  a_hb_one_bit: assert property (
    @(posedge clk) disable iff (srst || !mode_r)
    $rose(heartbeat_line_o) |-> s_hb_pulse)
    else $error("heartbeat not one bit period");
  a_code_at_rise: assert property (
    mode_r && $past(mode_r) && $changed(serial_time_code_o)
    |-> $rose(time_shift_clock_o))
    else $error("code changed off the rising edge");
  a_first_bit_msb: assert property (
    tx_stamp |-> serial_time_code_o == $past(time_in[`TSS_CODE_W-1]))
    else $error("first bit is not the time msb");
  a_rx_on_fall: assert property (
    rx_hb_mark |-> $past(sc_s3) && !$past(sc_s2))
    else $error("heartbeat taken off a falling edge");
  a_rx_full_code: assert property (
    rx_valid |-> chk_falls == 8'h2f)
    else $error("code length after heartbeat wrong");
  a_rx_quiet_drv: assert property (
    mode_r |=> !rx_valid && !rx_hb_mark)
    else $error("receive activity while driving");

endmodule

// ### tss_params.svh
/*
  constants for the time sync serial port: widths, frame layout, divider.
  assumes it is included by bare name wherever these figures are needed.
*/
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH

// ==========================================================
// time code frame
`define TSS_CODE_W 48
`define TSS_CODE_LAST 6'h2f
`define TSS_CNT_W 6
`define TSS_HB_BITS_LAST 7'h3f
`define TSS_BIT_W 7

// ==========================================================
// bit clock divider (core clocks per half period)
`define TSS_DIV_W 3
`define TSS_HALF_LAST 3'h3

`endif

// ### tss_pkg.sv
/*
  types and helpers shared by the time sync serial port modules.
  assumes nothing beyond a single core clock domain.
*/
package tss_pkg;

  // ==========================================================
  // receive state
  typedef enum logic {RX_IDLE, RX_SHIFT} tss_rx_state_t;

  // ==========================================================
  // edge helpers on two consecutive samples
  function automatic logic tss_rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  function automatic logic tss_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

endpackage

// ### tss_tick_if.sv
/*
  carrier between the port and its bit clock divider.
  assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`include "tss_params.svh"

interface tss_tick_if;
  logic run;
  logic lvl;
  logic rise_pre;
  logic [`TSS_BIT_W-1:0] bit_idx;

  modport gen
  (
    input run,
    output lvl,
    output rise_pre,
    output bit_idx
  );

  modport usr
  (
    output run,
    input lvl,
    input rise_pre,
    input bit_idx
  );
endinterface

// ### tss_bit_divider.sv
/*
  bit clock divider: makes the outgoing bit clock level, a pulse in the
  cycle before each rising edge and the index of the bit that edge opens.
  assumes run comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "tss_params.svh"

module tss_bit_divider
(
  input wire logic clk,
  input wire logic srst,
  tss_tick_if.gen tick
);

  logic [`TSS_DIV_W-1:0] div_r;
  logic [`TSS_DIV_W-1:0] div_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic [`TSS_BIT_W-1:0] idx_r;
  logic [`TSS_BIT_W-1:0] idx_nxt;
  logic wrap;

  // ==========================================================
  // next state
  always_comb
  begin
    wrap = (div_r == `TSS_HALF_LAST);
    div_nxt = div_r + 1'b1;
    lvl_nxt = lvl_r;
    idx_nxt = idx_r;
    if (!tick.run)
    begin
      div_nxt = '0;
      lvl_nxt = 1'b0;
      idx_nxt = '0;
    end
    else if (wrap)
    begin
      div_nxt = '0;
      lvl_nxt = ~lvl_r;
      // index moves on the falling edge, ready for the next rise
      if (lvl_r)
      begin
        idx_nxt = (idx_r == `TSS_HB_BITS_LAST) ? '0 : idx_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_r <= '0;
      lvl_r <= 1'b0;
      idx_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      lvl_r <= lvl_nxt;
      idx_r <= idx_nxt;
    end
  end

  assign tick.lvl = lvl_r;
  assign tick.rise_pre = tick.run & wrap & ~lvl_r;
  assign tick.bit_idx = idx_r;

endmodule

// ### tss_far_end.sv
/*
  behavioural far end of the three-line time port: sends time code
  frames toward the port and captures frames that the port drives.
  assumes the bench resolves each line from the port's enables alone.
*/
`timescale 1ns/1ps

module tss_far_end
(
  input wire logic hb_i,
  input wire logic sck_i,
  input wire logic code_i,
  input wire logic listen,
  output logic hb_o,
  output logic sck_o,
  output logic code_o
);
  logic busy = 1'b0;
  logic hb_p = 1'b0;
  logic on = 1'b0;
  logic [47:0] sh;
  logic [47:0] got_code;
  int n = 0;
  int per = 0;
  int hw = 0;
  int got_per;
  int got_hw;
  event got;

  initial
  begin
    hb_o = 1'b0;
    sck_o = 1'b0;
    code_o = 1'b0;
  end

  // ==========================================================
  // sending
  // code line is stale outside frames, so it keeps toggling
  always #40
    if (!busy)
      code_o = ~code_o;

  task automatic send(input logic [47:0] v, input int nb, input int hwid);
    busy = 1'b1;
    #7;
    for (int k = 0; k < nb + 1; k++)
    begin
      hb_o = (k < hwid);
      code_o = (k < nb) ? v[47-k] : ~code_o;
      #40 sck_o = 1'b1;
      #80 sck_o = 1'b0;
      #40;
    end
    hb_o = 1'b0;
    busy = 1'b0;
  endtask

  // ==========================================================
  // capture of driven frames, msb first, sampled on clock fall
  always @(negedge sck_i)
    if (listen)
    begin
      if (hb_i && !hb_p)
      begin
        per = n;
        n = 0;
        hw = 0;
        on = 1'b1;
      end
      hb_p = hb_i;
      if (on)
      begin
        sh = {sh[46:0], code_i};
        hw += hb_i;
        n++;
        if (n == 48)
        begin
          got_code = sh;
          got_per = per;
          got_hw = hw;
          ->got;
        end
      end
    end
endmodule

// ### tb_time_sync_serial_port.sv
/*
  self-checking bench for the time port: receive and drive directions.
  assumes tss_far_end as the far side and a 50 MHz core clock.
*/
`timescale 1ns/1ps
`include "tss_params.svh"

module tb_time_sync_serial_port;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic drive_mode = 1'b0;
  logic listen = 1'b0;
  logic [47:0] time_in = 48'h0;
  logic [47:0] v;
  logic hb_o, hb_oe_n, sck_o, sck_oe_n, code_o, code_oe_n;
  logic far_hb, far_sck, far_code, hb_w, sck_w, code_w;
  logic tx_stamp, rx_valid, rx_hb_mark, rx_frame_err;
  logic [47:0] rx_time;
  logic pc = 1'b0;
  logic ph = 1'b0;
  logic psck = 1'b0;
  logic [47:0] exp_rx[$];
  logic [47:0] exp_tx[$];
  int n_mismatch = 0;
  int checked = 0;
  int n_hb = 0;
  int n_err = 0;
  int n_got = 0;

  always #10 clk = ~clk;

  assign hb_w = (hb_oe_n === 1'b0) ? hb_o : far_hb;
  assign sck_w = (sck_oe_n === 1'b0) ? sck_o : far_sck;
  assign code_w = (code_oe_n === 1'b0) ? code_o : far_code;

  tss_port dut
  (
    .clk(clk), .srst(srst), .drive_mode(drive_mode), .time_in(time_in),
    .heartbeat_line_i(hb_w), .heartbeat_line_o(hb_o),
    .heartbeat_line_oe_n(hb_oe_n), .time_shift_clock_i(sck_w),
    .time_shift_clock_o(sck_o), .time_shift_clock_oe_n(sck_oe_n),
    .serial_time_code_i(code_w), .serial_time_code_o(code_o),
    .serial_time_code_oe_n(code_oe_n), .tx_stamp(tx_stamp),
    .rx_time(rx_time), .rx_valid(rx_valid), .rx_hb_mark(rx_hb_mark),
    .rx_frame_err(rx_frame_err)
  );

  tss_far_end far
  (
    .hb_i(hb_w), .sck_i(sck_w), .code_i(code_w), .listen(listen),
    .hb_o(far_hb), .sck_o(far_sck), .code_o(far_code)
  );

  // ==========================================================
  // helpers
  function automatic logic [47:0] rnd48();
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    return r[47:0];
  endfunction

  task automatic cmp_code(input logic [47:0] g, input logic [47:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %0t value %h, wanted %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // watchers
  always @(negedge clk)
  begin
    n_hb += (rx_hb_mark === 1'b1);
    n_err += (rx_frame_err === 1'b1);
    if (rx_valid === 1'b1)
      cmp_code(rx_time, exp_rx.size() ? exp_rx.pop_front() : ~rx_time);
    // outputs only move with a rising shift clock
    if ((code_o !== pc || hb_o !== ph) && code_oe_n === 1'b0 && !srst)
      cmp_code({47'h0, sck_o & ~psck}, 48'h1);
    pc = code_o;
    ph = hb_o;
    psck = sck_o;
    if (tx_stamp === 1'b1)
    begin
      exp_tx.push_back(time_in);
      @(posedge clk);
      #1 time_in = rnd48();
    end
  end

  always @(far.got)
  begin
    n_got++;
    cmp_code(far.got_code, exp_tx.size() ? exp_tx.pop_front() : 48'hx);
    cmp_code(48'(far.got_hw), 48'h1);
    if (far.got_per != 0)
      cmp_code(48'(far.got_per), 48'h40);
  end

  initial
  begin
    #600000;
    n_mismatch++;
    $display("unexpected %0t run did not finish", $time);
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(66797));
    time_in = rnd48();
    tick(10);
    srst = 1'b0;
    tick(2);
    v = rnd48();
    exp_rx.push_back(v);
    far.send(v, 48, 1);
    v = rnd48();
    exp_rx.push_back(v);
    far.send(v, 48, 1 + $urandom_range(2));
    // a frame cut short by a new heartbeat is dropped
    far.send(rnd48(), 20, 1);
    v = rnd48();
    exp_rx.push_back(v);
    far.send(v, 48, 1);
    tick(10);
    cmp_code({47'h0, hb_oe_n & sck_oe_n & code_oe_n}, 48'h1);
    drive_mode = 1'b1;
    listen = 1'b1;
    for (int i = 0; i < 3000 && n_got < 3; i++)
      tick(1);
    cmp_code({47'h0, hb_oe_n | sck_oe_n | code_oe_n}, 48'h0);
    drive_mode = 1'b0;
    listen = 1'b0;
    tick(3);
    cmp_code({45'h0, hb_oe_n, sck_oe_n, code_oe_n}, 48'h7);
    cmp_code({45'h0, hb_o, sck_o, code_o}, 48'h0);
    v = rnd48();
    exp_rx.push_back(v);
    far.send(v, 48, 2);
    tick(10);
    cmp_code(48'(n_got), 48'h3);
    cmp_code(48'(n_hb), 48'h5);
    cmp_code(48'(n_err), 48'h1);
    cmp_code(48'(exp_rx.size() + exp_tx.size()), 48'h0);
    give_verdict();
  end
endmodule
